/* File: hdl/mqr_pkg.sv */
// Shared constants and types for the multi-queue read select and flag block.
// Assumes one clock drives both ports; all users refer to names as mqr_pkg::name.
package mqr_pkg;

  // Data and selection widths
  localparam int DATA_W = 18;
  localparam int QUEUE_CNT = 4;
  localparam int QSEL_W = 2;
  localparam int RSEL_W = 3;
  localparam int DEV_W = 3;
  localparam int FIFO_DEPTH = 8;
  localparam int LEVEL_W = 4;

  // Read select code that names the null queue
  localparam logic [RSEL_W-1:0] NULL_QUEUE = 3'h4;

  // Almost-full boundary: flag active once the free space drops to this
  localparam logic [LEVEL_W-1:0] AF_OFFSET = 4'h2;
  localparam logic [LEVEL_W-1:0] AF_LEVEL = 4'h8 - AF_OFFSET;

  // Queue switch latency in clock cycles, on both ports
  localparam int SWITCH_CYCLES = 3;

  // Reset values
  localparam logic [DATA_W-1:0] OUT_RST = 18'h00000;
  localparam logic [DEV_W-1:0] DEV_RST = 3'h0;
  localparam logic [QSEL_W-1:0] WQ_RST = 2'h0;

  // Read switch sequence: idle, then three edges toward the new queue
  typedef enum logic [1:0] {
    RS_IDLE,
    RS_SW1,
    RS_SW2,
    RS_SW3
  } mqr_rd_state_type;

endpackage : mqr_pkg

/* File: hdl/mqr_fifo.sv */
// One queue of the device: a small synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two; output word is visible while out_valid_o is high.
`timescale 1ns/10ps
module mqr_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH+1)-1:0] level_o
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic push;
  logic pop;

  // Honest flags straight from the fill count
  assign in_ready_o = (count != CW'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  assign level_o = count;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Storage has no reset; only pointers and the fill count need a defined start
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // Pointers wrap naturally at a power-of-two depth
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
    end
  end

  // Fill count
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      count <= '0;
    end else begin
      unique case ({push, pop})
        2'b10: count <= count + CW'(1);
        2'b01: count <= count - CW'(1);
        2'b00, 2'b11: count <= count;
      endcase
    end
  end

endmodule : mqr_fifo

/* File: hdl/mqr_top.sv */
// Read-port queue switching, output-valid and almost-full flags of a multi-queue FIFO.
// Assumes controller inputs are synchronous to ref_clk_i; expansion devices share selects.
//
// Overview of operation
// R1 - Data from a newly selected read queue appears three clocks after selection.
// R2 - During the switch interval the old queue still supplies its next word.
// R3 - First word of a non-empty new queue falls through three clocks later regardless.
// R4 - Empty new queue: previous last word stays, output-valid goes high.
// R5 - Output-valid goes high the cycle after the last word is read.
// R6 - Output-valid reflects the new read queue three clocks after selection.
// R7 - Write into empty selected queue makes word fall through, valid low.
// R8 - New owner device drives data and valid; previous owner releases them.
// R9 - With read advance high and no fall-through, output word holds.
// R10 - Enabled reads right after a selection return old queue words.
// R11 - Output enable acts asynchronously on the data output drivers.
// R12 - Null queue acts like an empty queue; last word stays, valid high.
// R13 - Controller leaves at least four clocks between read queue selections.
// R14 - Almost-full follows a new write queue three clocks after selection.
// R15 - Write crossing the almost-full boundary drives the flag low two clocks later.
// R16 - Unselected device keeps its almost-full output released until selection latency.
// R17 - Almost-full goes inactive after switching to a queue not almost full.
// R18 - Read and write side updates are all registered on rising clock edges; the data output enable q_oe_n_o is an unregistered gate.
`timescale 1ns/10ps
module mqr_top #(
  parameter logic [2:0] DEV_ID = 3'h0
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic wr_sel_load_i,
  input wire logic [mqr_pkg::DEV_W-1:0] wr_sel_dev_i,
  input wire logic [mqr_pkg::QSEL_W-1:0] wr_sel_queue_i,
  input wire logic wr_en_n_i,
  input wire logic [mqr_pkg::DATA_W-1:0] wr_data_i,
  input wire logic rd_sel_load_i,
  input wire logic [mqr_pkg::DEV_W-1:0] rd_sel_dev_i,
  input wire logic [mqr_pkg::RSEL_W-1:0] rd_sel_queue_i,
  input wire logic rd_en_n_i,
  input wire logic out_en_n_i,
  output logic [mqr_pkg::DATA_W-1:0] q_o,
  output logic q_oe_n_o,
  output logic output_valid_n_o,
  output logic output_valid_oe_n_o,
  output logic almost_full_n_o,
  output logic almost_full_oe_n_o,
  output logic wr_ready_o
);

  // Queue storage interface, one slot per queue
  logic fifo_in_valid [mqr_pkg::QUEUE_CNT];
  logic fifo_in_ready [mqr_pkg::QUEUE_CNT];
  logic fifo_out_valid [mqr_pkg::QUEUE_CNT];
  logic fifo_out_ready [mqr_pkg::QUEUE_CNT];
  logic [mqr_pkg::DATA_W-1:0] fifo_out_data [mqr_pkg::QUEUE_CNT];
  logic [mqr_pkg::LEVEL_W-1:0] fifo_level [mqr_pkg::QUEUE_CNT];

  // Read side state
  mqr_pkg::mqr_rd_state_type rd_state;
  logic [mqr_pkg::DEV_W-1:0] rd_cur_dev;
  logic [mqr_pkg::RSEL_W-1:0] rd_cur_q;
  logic [mqr_pkg::DEV_W-1:0] rd_pend_dev;
  logic [mqr_pkg::RSEL_W-1:0] rd_pend_q;
  logic [mqr_pkg::DATA_W-1:0] out_word;
  logic out_valid_n;
  logic rd_drive_n;

  // Read side decode
  logic [mqr_pkg::DEV_W-1:0] rd_dev;
  logic [mqr_pkg::RSEL_W-1:0] rd_q;
  logic [mqr_pkg::QSEL_W-1:0] rd_idx;
  logic rd_real;
  logic rd_avail;
  logic rd_force;
  logic rd_take;

  // Write side state and flag pipeline
  logic wr_own;
  logic [mqr_pkg::QSEL_W-1:0] wr_q;
  logic wf_own_d1;
  logic [mqr_pkg::QSEL_W-1:0] wf_q_d1;
  logic wf_own_d2;
  logic [mqr_pkg::LEVEL_W-1:0] af_level;
  logic almost_full_n;
  logic af_drive_n;
  logic wr_ready;

  // A read select names a real queue of this device, not the null queue
  function automatic logic queue_real(input logic [mqr_pkg::DEV_W-1:0] dev,
                                      input logic [mqr_pkg::RSEL_W-1:0] q);
    queue_real = (dev == DEV_ID) && (q != mqr_pkg::NULL_QUEUE);
  endfunction : queue_real

  // One storage FIFO per queue
  for (genvar g = 0; g < mqr_pkg::QUEUE_CNT; g++) begin : g_queue
    mqr_fifo #(
      .WIDTH(mqr_pkg::DATA_W),
      .DEPTH(mqr_pkg::FIFO_DEPTH)
    ) u_fifo (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(fifo_in_valid[g]),
      .in_ready_o(fifo_in_ready[g]),
      .in_data_i(wr_data_i),
      .out_valid_o(fifo_out_valid[g]),
      .out_ready_i(fifo_out_ready[g]),
      .out_data_o(fifo_out_data[g]),
      .level_o(fifo_level[g])
    );

    // Writes land only in the selected queue of the owning device
    assign fifo_in_valid[g] = !wr_en_n_i && wr_own && (wr_q == g);
    // Pop only the queue feeding the output register this edge
    assign fifo_out_ready[g] = rd_take && (rd_idx == g);
  end

  // Read switch sequence; selections during a switch are ignored
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rd_state <= mqr_pkg::RS_IDLE;
    end else begin
      unique case (rd_state)
        mqr_pkg::RS_IDLE: begin
          if (rd_sel_load_i) begin
            rd_state <= mqr_pkg::RS_SW1; // R18
          end
        end
        mqr_pkg::RS_SW1: rd_state <= mqr_pkg::RS_SW2; // R13
        mqr_pkg::RS_SW2: rd_state <= mqr_pkg::RS_SW3;
        mqr_pkg::RS_SW3: rd_state <= mqr_pkg::RS_IDLE; // R1
      endcase
    end
  end

  // Pending and current read selection
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rd_pend_dev <= mqr_pkg::DEV_RST;
      rd_pend_q <= mqr_pkg::NULL_QUEUE;
      rd_cur_dev <= mqr_pkg::DEV_RST;
      rd_cur_q <= mqr_pkg::NULL_QUEUE;
    end else begin
      if (rd_state == mqr_pkg::RS_IDLE && rd_sel_load_i) begin
        rd_pend_dev <= rd_sel_dev_i;
        rd_pend_q <= rd_sel_queue_i;
      end
      // Old queue stays current until the third edge
      if (rd_state == mqr_pkg::RS_SW3) begin
        rd_cur_dev <= rd_pend_dev; // R1
        rd_cur_q <= rd_pend_q;
      end
    end
  end

  // Which queue feeds the output register, and whether it advances
  always_comb begin
    rd_dev = (rd_state == mqr_pkg::RS_SW3) ? rd_pend_dev : rd_cur_dev; // R10
    rd_q = (rd_state == mqr_pkg::RS_SW3) ? rd_pend_q : rd_cur_q;
    rd_idx = rd_q[mqr_pkg::QSEL_W-1:0];
    rd_real = queue_real(rd_dev, rd_q); // R12
    rd_avail = rd_real && fifo_out_valid[rd_idx];
    // Second edge refills from the old queue, third loads the new one
    rd_force = (rd_state == mqr_pkg::RS_SW2) || (rd_state == mqr_pkg::RS_SW3); // R2 R3
    // Empty output register pulls a word in regardless of read advance
    rd_take = rd_avail && (rd_force || out_valid_n || !rd_en_n_i); // R7 R9
  end

  // Output register: holds its word unless a word is taken
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      out_word <= mqr_pkg::OUT_RST;
    end else if (rd_take) begin
      out_word <= fifo_out_data[rd_idx]; // R3 R9
    end
  end

  // Output-valid: stale word stays on the bus but is marked as read
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      out_valid_n <= 1'b1;
    end else if (rd_take) begin
      out_valid_n <= 1'b0; // R7
    end else if (rd_state == mqr_pkg::RS_SW3) begin
      out_valid_n <= 1'b1; // R4 R6 R12
    end else if (!rd_en_n_i) begin
      out_valid_n <= 1'b1; // R5
    end
  end

  // Bus ownership in expansion moves at the third edge on every device
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rd_drive_n <= 1'b1;
    end else if (rd_state == mqr_pkg::RS_SW3) begin
      rd_drive_n <= (rd_pend_dev != DEV_ID); // R8
    end
  end

  // Read outputs straight from their registers
  assign q_o = out_word;
  assign output_valid_n_o = out_valid_n;
  assign output_valid_oe_n_o = rd_drive_n; // R8
  // Gate only, no edge: output enable must reach the pads at once
  assign q_oe_n_o = out_en_n_i | rd_drive_n; // R11

  // Write queue selection takes effect for data on the next edge
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wr_own <= 1'b0;
      wr_q <= mqr_pkg::WQ_RST;
    end else if (wr_sel_load_i) begin
      wr_own <= (wr_sel_dev_i == DEV_ID); // R18
      wr_q <= wr_sel_queue_i;
    end
  end

  // Ownership delayed twice, queue index once; the level stage makes up the second edge
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wf_own_d1 <= 1'b0;
      wf_q_d1 <= mqr_pkg::WQ_RST;
      wf_own_d2 <= 1'b0;
    end else begin
      wf_own_d1 <= wr_own; // R14
      wf_q_d1 <= wr_q;
      wf_own_d2 <= wf_own_d1;
    end
  end

  // Level registered once, so a crossing write shows on the flag two edges later
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      af_level <= '0;
      almost_full_n <= 1'b1;
    end else begin
      af_level <= fifo_level[wf_q_d1]; // R15
      almost_full_n <= (af_level < mqr_pkg::AF_LEVEL); // R15 R17
    end
  end

  // Flag driver stays released until ownership has passed the latency
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      af_drive_n <= 1'b1;
    end else begin
      af_drive_n <= !wf_own_d2; // R16
    end
  end

  // Back-pressure toward the writer; a write seen while full is dropped
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wr_ready <= 1'b0;
    end else begin
      wr_ready <= wr_own && fifo_in_ready[wr_q];
    end
  end

  assign almost_full_n_o = almost_full_n;
  assign almost_full_oe_n_o = af_drive_n;
  assign wr_ready_o = wr_ready;

endmodule : mqr_top

/* File: verification/mqr_top_properties.sv */
// Port-level checks for mqr_top, attached to every instance by bind.
// Assumes one clock domain and the synchronous active low reset.
`timescale 1ns/10ps
module mqr_top_properties #(
  parameter logic [2:0] DEV_ID = 3'h0
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic wr_sel_load_i,
  input wire logic [mqr_pkg::DEV_W-1:0] wr_sel_dev_i,
  input wire logic wr_en_n_i,
  input wire logic rd_sel_load_i,
  input wire logic [mqr_pkg::DEV_W-1:0] rd_sel_dev_i,
  input wire logic [mqr_pkg::RSEL_W-1:0] rd_sel_queue_i,
  input wire logic rd_en_n_i,
  input wire logic out_en_n_i,
  input wire logic [mqr_pkg::DATA_W-1:0] q_o,
  input wire logic q_oe_n_o,
  input wire logic output_valid_n_o,
  input wire logic output_valid_oe_n_o,
  input wire logic almost_full_n_o,
  input wire logic almost_full_oe_n_o
);
  logic [1:0] sw_cnt;

  // Switch window; loads inside it are dropped, so they must not restart it
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) sw_cnt <= 2'h0;
    else if (sw_cnt != 2'h0) sw_cnt <= sw_cnt - 2'h1;
    else if (rd_sel_load_i) sw_cnt <= 2'h3;
  end

  default clocking dc @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_OE_ASYNC: assert property (out_en_n_i |-> q_oe_n_o)
    else $error("data driver on while output enable off");
  AST_HOLD: assert property (sw_cnt == 2'h0 && rd_en_n_i && !output_valid_n_o |=> $stable(q_o))
    else $error("valid word changed without read advance");
  AST_READ_ADV: assert property (sw_cnt == 2'h0 && !rd_en_n_i && !output_valid_n_o
    |=> $changed(q_o) || output_valid_n_o)
    else $error("read of valid word neither advanced nor cleared valid");
  AST_NULL: assert property (rd_sel_load_i && sw_cnt == 2'h0 && rd_sel_queue_i == mqr_pkg::NULL_QUEUE
    |-> ##4 output_valid_n_o && $stable(q_o))
    else $error("null queue select did not hold word with valid off");
  AST_VOE_DEV: assert property (rd_sel_load_i && sw_cnt == 2'h0
    |-> ##4 output_valid_oe_n_o == ($past(rd_sel_dev_i, 4) != DEV_ID))
    else $error("valid driver does not follow selected device");
  AST_VOE_PRE: assert property (rd_sel_load_i && sw_cnt == 2'h0
    |=> $stable(output_valid_oe_n_o) [*3])
    else $error("valid driver moved before switch latency");
  AST_AF_OE: assert property (wr_sel_load_i ##1 !wr_sel_load_i [*3]
    |=> almost_full_oe_n_o == ($past(wr_sel_dev_i, 4) != DEV_ID))
    else $error("almost-full driver does not follow write device");
  AST_AF_CAUSE: assert property ($fell(almost_full_n_o)
    |-> !$past(wr_en_n_i, 3) || $past(wr_sel_load_i, 4))
    else $error("almost-full asserted without write or switch");
  AST_VALID_FALL: assert property ($fell(output_valid_n_o) |-> $changed(q_o))
    else $error("valid asserted without a new word");
endmodule : mqr_top_properties

bind mqr_top mqr_top_properties #(.DEV_ID(DEV_ID)) mqr_top_properties_inst (.*);

/* File: verification/mqr_wr_model.sv */
// Writing controller model: a burst of count_i words from base_i, one per cycle.
// Assumes start_i is a one-cycle pulse; changes outputs on the falling edge.
`timescale 1ns/10ps
module mqr_wr_model (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [3:0] count_i,
  input wire logic [mqr_pkg::DATA_W-1:0] base_i,
  output logic wr_en_n_o,
  output logic [mqr_pkg::DATA_W-1:0] wr_data_o
);
  logic [3:0] left;

  // Idle data is inverted so a stale word never looks like a fresh one
  always_ff @(negedge ref_clk_i) begin
    if (!rst_n_i) begin
      left <= 4'h0;
      wr_en_n_o <= 1'h1;
      wr_data_o <= '1;
    end else if (start_i) begin
      left <= count_i - 4'h1;
      wr_en_n_o <= 1'h0;
      wr_data_o <= base_i;
    end else if (left != 4'h0) begin
      left <= left - 4'h1;
      wr_data_o <= wr_data_o + 18'h00001;
    end else begin
      wr_en_n_o <= 1'h1;
      wr_data_o <= ~wr_data_o;
    end
  end
endmodule : mqr_wr_model

/* File: verification/mqr_top_tb_top.sv */
// Self-checking bench for mqr_top: read switching, valid flag, drivers, almost-full.
// Assumes DEV_ID 0; the bench is the reader, the writer model feeds the write port.
`timescale 1ns/10ps
module mqr_top_tb_top;
  logic ref_clk_i = 1'h1;
  logic rst_n_i = 1'h0;
  logic wsl = 1'h0, rsl = 1'h0, ren_n = 1'h1, oen_n = 1'h0, st = 1'h0;
  logic [2:0] rdev = 3'h0, rq = 3'h4, wdev = 3'h0;
  logic [1:0] wq = 2'h0;
  logic [3:0] cnt = 4'h0;
  logic [17:0] base = 18'h00000, q, wd;
  logic wen_n, qoe_n, ov_n, ovoe_n, af_n, afoe_n, wrdy;
  int error_cnt = 0;
  int num_checks = 0;

  mqr_top mqr_top_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .wr_sel_load_i(wsl),
    .wr_sel_dev_i(wdev), .wr_sel_queue_i(wq), .wr_en_n_i(wen_n), .wr_data_i(wd),
    .rd_sel_load_i(rsl), .rd_sel_dev_i(rdev), .rd_sel_queue_i(rq), .rd_en_n_i(ren_n),
    .out_en_n_i(oen_n), .q_o(q), .q_oe_n_o(qoe_n), .output_valid_n_o(ov_n),
    .output_valid_oe_n_o(ovoe_n), .almost_full_n_o(af_n), .almost_full_oe_n_o(afoe_n),
    .wr_ready_o(wrdy));
  mqr_wr_model mqr_wr_model_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .start_i(st),
    .count_i(cnt), .base_i(base), .wr_en_n_o(wen_n), .wr_data_o(wd));

  // Clock and watchdog; whole run needs well under 300 cycles
  initial forever #5 ref_clk_i = ~ref_clk_i;
  initial begin
    repeat (2000) @(posedge ref_clk_i);
    error_cnt++;
    results();
  end

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      @(negedge ref_clk_i);
    end
  endtask : tick

  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Selects are spaced by callers, at least four edges apart
  task automatic rsel(input logic [2:0] d, input logic [2:0] x);
    rsl = 1'h1;
    rdev = d;
    rq = x;
    tick(1);
    rsl = 1'h0;
  endtask : rsel

  task automatic wsel(input logic [1:0] x);
    wsl = 1'h1;
    wq = x;
    tick(1);
    wsl = 1'h0;
  endtask : wsel

  // Model sees the pulse one falling edge later, then writes n words
  task automatic wr(input logic [3:0] n, input logic [17:0] b);
    st <= 1'h1;
    cnt <= n;
    base <= b;
    tick(1);
    st <= 1'h0;
    tick(n);
  endtask : wr

  task automatic t_af;
    wsel(2'h0);
    tick(3);
    chk(afoe_n, 1'h0);
    chk(wrdy, 1'h1);
    wr(4'h6, 18'h00010);
    tick(1);
    chk(af_n, 1'h1);
    tick(1);
    chk(af_n, 1'h0);
    wsel(2'h1);
    tick(2);
    chk(af_n, 1'h0);
    tick(1);
    chk(af_n, 1'h1);
    wsel(2'h0);
    tick(3);
    $display("t_af done");
  endtask : t_af

  task automatic t_read;
    rsel(3'h0, 3'h0);
    tick(2);
    chk(ov_n, 1'h1);
    tick(1);
    chk(q, 18'h00010);
    chk(ov_n, 1'h0);
    chk(ovoe_n, 1'h0);
    tick(2);
    chk(q, 18'h00010);
    ren_n = 1'h0;
    for (int i = 1; i < 6; i++) begin
      tick(1);
      chk(q, 18'h00010 + 18'(i));
    end
    tick(1);
    chk(ov_n, 1'h1);
    ren_n = 1'h1;
    wr(4'h1, 18'h00020);
    tick(1);
    chk(q, 18'h00020);
    chk(ov_n, 1'h0);
    $display("t_read done");
  endtask : t_read

  task automatic t_null;
    wr(4'h2, 18'h00030);
    ren_n = 1'h0;
    rsel(3'h0, mqr_pkg::NULL_QUEUE);
    chk(q, 18'h00030);
    ren_n = 1'h1;
    tick(2);
    chk(q, 18'h00031);
    tick(1);
    chk(q, 18'h00031);
    chk(ov_n, 1'h1);
    $display("t_null done");
  endtask : t_null

  task automatic t_dev;
    rsel(3'h1, 3'h0);
    tick(2);
    chk(ovoe_n, 1'h0);
    tick(1);
    chk(ovoe_n, 1'h1);
    chk(qoe_n, 1'h1);
    tick(1);
    rsel(3'h0, 3'h0);
    tick(3);
    chk(qoe_n, 1'h0);
    oen_n = 1'h1;
    #1;
    chk(qoe_n, 1'h1);
    tick(1);
    oen_n = 1'h0;
    #1;
    chk(qoe_n, 1'h0);
    $display("t_dev done");
  endtask : t_dev

  // Write port handed to another device: flag driver released after the latency
  task automatic t_wdev;
    tick(1);
    wdev = 3'h1;
    wsel(2'h0);
    tick(2);
    chk(afoe_n, 1'h0);
    chk(wrdy, 1'h0);
    tick(1);
    chk(afoe_n, 1'h1);
    wdev = 3'h0;
    wsel(2'h0);
    tick(2);
    chk(afoe_n, 1'h1);
    tick(1);
    chk(afoe_n, 1'h0);
    $display("t_wdev done");
  endtask : t_wdev

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  // Reset for 16 cycles, then the scenarios in order
  initial begin
    tick(16);
    rst_n_i = 1'h1;
    chk(q, 18'h00000);
    chk(ov_n, 1'h1);
    chk(afoe_n, 1'h1);
    chk(wrdy, 1'h0);
    t_af();
    t_read();
    t_null();
    t_dev();
    t_wdev();
    results();
  end
endmodule : mqr_top_tb_top
